// ### design/adc_seq_regs.svh
`ifndef ADC_SEQ_REGS_SVH
`define ADC_SEQ_REGS_SVH
// Register byte addresses
`define ADDR_CTRL 8'h00
`define ADDR_CHAN 8'h04
`define ADDR_RES_LO 8'h08
`define ADDR_RES_HI 8'h0C
`define ADDR_SPECIAL 8'h10
// Control and status fields
`define CTRL_EN 7
`define CTRL_START 6
`define CTRL_AUTO 5
`define CTRL_FLAG 4
`define CTRL_PS 2:0
// Channel select fields
`define CHAN_REF 7:6
`define CHAN_LADJ 5
`define CHAN_MUX 4:0
// Special function fields
`define SPEC_TSEL 7:5
// Trigger source code meaning own completion flag
`define TSEL_FREE 3'h0
// First differential channel code
`define DIFF_FIRST 5'h08
// Conversion lengths and sample points, in half converter cycles
`define HC_NORMAL 6'h1A
`define HC_DIFF 6'h1C
`define HC_FIRST 6'h32
`define SH_NORMAL 6'h03
`define SH_FIRST 6'h1B
`define SH_AUTO 6'h04
// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ### design/adc_seq_pkg.sv
package adc_seq_pkg;
   typedef enum logic [2:0] {
      S_IDLE = 3'b001,
      S_ARMED = 3'b010,
      S_CONV = 3'b100
   } seq_state_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic aw_got;
      logic w_got;
      logic [7:0] waddr;
      logic [7:0] wdata;
      logic wlane0;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [7:0] rdata;
      logic [1:0] rresp;
   } bus_state_t;

   typedef struct packed {
      bus_state_t bus;
      seq_state_t st;
      logic enable;
      logic auto_en;
      logic flag;
      logic [2:0] ps;
      logic [1:0] ref_sw;
      logic ladj;
      logic [4:0] chan_sw;
      logic [2:0] tsel;
      logic [1:0] ref_buf;
      logic [4:0] chan_buf;
      logic [1:0] ref_out;
      logic [4:0] chan_out;
      logic [9:0] result;
      logic lock;
      logic [6:0] presc;
      logic hrclk;
      logic [5:0] hcnt;
      logic [5:0] len;
      logic [5:0] sh_at;
      logic first;
      logic trig_prev;
      logic trig_p1;
      logic trig_p2;
      logic sample;
      logic done;
      logic busy;
   } seq_regs_t;
endpackage

// ### design/adc_conversion_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
`include "adc_seq_regs.svh"
module adc_conversion_sequencer (
   input wire logic CLK_SYS_I, // 125 MHz system clock
   input wire logic RESETN_I, // Async reset, active low
   input wire logic [7:0] S_AXI_AWADDR_I, // Write address
   input wire logic S_AXI_AWVALID_I, // Write address valid
   output logic S_AXI_AWREADY_O, // Write address ready
   input wire logic [31:0] S_AXI_WDATA_I, // Write data
   input wire logic [3:0] S_AXI_WSTRB_I, // Write byte enables
   input wire logic S_AXI_WVALID_I, // Write data valid
   output logic S_AXI_WREADY_O, // Write data ready
   output logic [1:0] S_AXI_BRESP_O, // Write response
   output logic S_AXI_BVALID_O, // Write response valid
   input wire logic S_AXI_BREADY_I, // Write response ready
   input wire logic [7:0] S_AXI_ARADDR_I, // Read address
   input wire logic S_AXI_ARVALID_I, // Read address valid
   output logic S_AXI_ARREADY_O, // Read address ready
   output logic [31:0] S_AXI_RDATA_O, // Read data
   output logic [1:0] S_AXI_RRESP_O, // Read response
   output logic S_AXI_RVALID_O, // Read data valid
   input wire logic S_AXI_RREADY_I, // Read data ready
   input wire logic [7:0] TRIGGER_I, // Trigger source flags
   input wire logic [9:0] SAR_RESULT_I, // Code from comparator core
   output logic ENABLE_O, // Analog circuitry enable
   output logic [4:0] CHANNEL_O, // Applied channel and gain
   output logic [1:0] REFERENCE_O, // Applied reference
   output logic SAMPLE_O, // Sample-and-hold strobe
   output logic DONE_O, // Conversion complete strobe
   output logic BUSY_O // Conversion in progress
);
   adc_seq_pkg::seq_regs_t cur_ff, nxt_cur;

   // Divider limit: ratio 2 for codes 0 and 1, else 2 to the code
   function automatic logic [6:0] presc_limit(input logic [2:0] ps);
      logic [7:0] r;
      r = 8'h01 << ((ps == 3'h0) ? 3'h1 : ps);
      return 7'(r - 8'h01);
   endfunction

   // Aligned result byte for a given register address
   function automatic logic [7:0] align(input logic [9:0] r, input logic ladj,
         input logic hi);
      logic [15:0] w;
      w = ladj ? {r, 6'h00} : {6'h00, r};
      return hi ? w[15:8] : w[7:0];
   endfunction

   logic [6:0] lim;
   logic full_tick, half_tick, tick, trig_now, fire, diff, free_run;
   logic wr_do, rd_do, mapped_w, mapped_r, do_start, at_sh, at_end;

   // Sequencing and bus, all state computed as one copy
   always_comb begin
      nxt_cur = cur_ff;
      nxt_cur.sample = 1'b0;
      nxt_cur.done = 1'b0;
      lim = presc_limit(cur_ff.ps);
      diff = (cur_ff.chan_buf >= `DIFF_FIRST);
      free_run = (cur_ff.tsel == `TSEL_FREE);

      // Write channel: address and data may arrive in either order
      if (S_AXI_AWVALID_I && cur_ff.bus.awready) begin
         nxt_cur.bus.aw_got = 1'b1;
         nxt_cur.bus.waddr = S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && cur_ff.bus.wready) begin
         nxt_cur.bus.w_got = 1'b1;
         nxt_cur.bus.wdata = S_AXI_WDATA_I[7:0];
         nxt_cur.bus.wlane0 = S_AXI_WSTRB_I[0];
      end
      wr_do = nxt_cur.bus.aw_got && nxt_cur.bus.w_got && !cur_ff.bus.bvalid;
      mapped_w = (nxt_cur.bus.waddr == `ADDR_CTRL) || (nxt_cur.bus.waddr == `ADDR_CHAN)
         || (nxt_cur.bus.waddr == `ADDR_RES_LO) || (nxt_cur.bus.waddr == `ADDR_RES_HI)
         || (nxt_cur.bus.waddr == `ADDR_SPECIAL);
      do_start = 1'b0;
      if (wr_do) begin
         nxt_cur.bus.aw_got = 1'b0;
         nxt_cur.bus.w_got = 1'b0;
         nxt_cur.bus.bvalid = 1'b1;
         nxt_cur.bus.bresp = mapped_w ? `RESP_OKAY : `RESP_SLVERR;
         // Only byte lane 0 carries bits; upper lanes are ignored
         if (nxt_cur.bus.wlane0) begin
            case (nxt_cur.bus.waddr)
               `ADDR_CTRL: begin
                  nxt_cur.enable = nxt_cur.bus.wdata[`CTRL_EN];
                  nxt_cur.auto_en = nxt_cur.bus.wdata[`CTRL_AUTO];
                  nxt_cur.ps = nxt_cur.bus.wdata[`CTRL_PS];
                  do_start = nxt_cur.bus.wdata[`CTRL_START];
                  if (nxt_cur.bus.wdata[`CTRL_FLAG]) begin
                     nxt_cur.flag = 1'b0;
                  end
               end
               `ADDR_CHAN: begin
                  nxt_cur.ref_sw = nxt_cur.bus.wdata[`CHAN_REF];
                  nxt_cur.ladj = nxt_cur.bus.wdata[`CHAN_LADJ];
                  nxt_cur.chan_sw = nxt_cur.bus.wdata[`CHAN_MUX];
               end
               `ADDR_SPECIAL: nxt_cur.tsel = nxt_cur.bus.wdata[`SPEC_TSEL];
               default: ;
            endcase
         end
      end
      if (cur_ff.bus.bvalid && S_AXI_BREADY_I) begin
         nxt_cur.bus.bvalid = 1'b0;
      end

      // Read channel; result byte reads steer the update lock
      rd_do = S_AXI_ARVALID_I && cur_ff.bus.arready;
      mapped_r = (S_AXI_ARADDR_I == `ADDR_CTRL) || (S_AXI_ARADDR_I == `ADDR_CHAN)
         || (S_AXI_ARADDR_I == `ADDR_RES_LO) || (S_AXI_ARADDR_I == `ADDR_RES_HI)
         || (S_AXI_ARADDR_I == `ADDR_SPECIAL);
      if (cur_ff.bus.rvalid && S_AXI_RREADY_I) begin
         nxt_cur.bus.rvalid = 1'b0;
      end
      if (rd_do) begin
         nxt_cur.bus.rvalid = 1'b1;
         nxt_cur.bus.rresp = mapped_r ? `RESP_OKAY : `RESP_SLVERR;
         case (S_AXI_ARADDR_I)
            `ADDR_CTRL: nxt_cur.bus.rdata = {cur_ff.enable,
               (cur_ff.st != adc_seq_pkg::S_IDLE), cur_ff.auto_en, cur_ff.flag,
               1'b0, cur_ff.ps};
            `ADDR_CHAN: nxt_cur.bus.rdata = {cur_ff.ref_sw, cur_ff.ladj, cur_ff.chan_sw};
            `ADDR_RES_LO: begin
               nxt_cur.bus.rdata = align(cur_ff.result, cur_ff.ladj, 1'b0);
               nxt_cur.lock = 1'b1;
            end
            `ADDR_RES_HI: begin
               nxt_cur.bus.rdata = align(cur_ff.result, cur_ff.ladj, 1'b1);
               nxt_cur.lock = 1'b0;
            end
            `ADDR_SPECIAL: nxt_cur.bus.rdata = {cur_ff.tsel, 5'h00};
            default: nxt_cur.bus.rdata = 8'h00;
         endcase
      end

      // Prescaler runs only while enabled, wraps at power-of-two limit
      full_tick = cur_ff.enable && (cur_ff.presc == lim);
      half_tick = cur_ff.enable && (cur_ff.presc == (lim >> 1));
      tick = full_tick || half_tick;
      nxt_cur.presc = full_tick ? 7'h00 : 7'(cur_ff.presc + 7'h01);
      if (full_tick) begin
         nxt_cur.hrclk = !cur_ff.hrclk;
      end

      // Trigger edge detect plus two more stages: three CPU cycles of sync
      trig_now = free_run ? 1'b0 : TRIGGER_I[cur_ff.tsel];
      nxt_cur.trig_prev = trig_now;
      nxt_cur.trig_p1 = trig_now && !cur_ff.trig_prev && cur_ff.auto_en && cur_ff.enable;
      nxt_cur.trig_p2 = cur_ff.trig_p1;
      fire = cur_ff.trig_p2 && cur_ff.auto_en && cur_ff.enable;

      at_sh = tick && (6'(cur_ff.hcnt + 6'h01) == cur_ff.sh_at);
      at_end = tick && (6'(cur_ff.hcnt + 6'h01) == cur_ff.len);

      case (cur_ff.st)
         adc_seq_pkg::S_IDLE: begin
            if (fire) begin
               // Restarting the divider fixes the delay from edge to sample
               nxt_cur.presc = 7'h00;
               nxt_cur.st = adc_seq_pkg::S_CONV;
               nxt_cur.hcnt = 6'h00;
               nxt_cur.len = cur_ff.first ? `HC_FIRST : `HC_NORMAL;
               nxt_cur.sh_at = cur_ff.first ? `SH_FIRST : `SH_AUTO;
               nxt_cur.first = 1'b0;
            end else if (do_start && nxt_cur.enable) begin
               nxt_cur.st = adc_seq_pkg::S_ARMED;
            end
         end
         adc_seq_pkg::S_ARMED: begin
            if (full_tick) begin
               nxt_cur.st = adc_seq_pkg::S_CONV;
               nxt_cur.hcnt = 6'h00;
               if (cur_ff.first) begin
                  nxt_cur.len = `HC_FIRST;
                  nxt_cur.sh_at = `SH_FIRST;
               end else begin
                  nxt_cur.len = (diff && cur_ff.hrclk) ? `HC_DIFF : `HC_NORMAL;
                  nxt_cur.sh_at = `SH_NORMAL;
               end
               nxt_cur.first = 1'b0;
            end
         end
         adc_seq_pkg::S_CONV: begin
            if (tick) begin
               nxt_cur.hcnt = 6'(cur_ff.hcnt + 6'h01);
            end
            nxt_cur.sample = at_sh;
            if (at_end) begin
               nxt_cur.done = 1'b1;
               if (!cur_ff.lock) begin
                  nxt_cur.result = SAR_RESULT_I;
               end
               nxt_cur.hcnt = 6'h00;
               if (cur_ff.auto_en && free_run) begin
                  // Back to back, start bit stays high throughout
                  nxt_cur.len = diff ? `HC_DIFF : `HC_NORMAL;
                  nxt_cur.sh_at = `SH_NORMAL;
               end else begin
                  nxt_cur.st = adc_seq_pkg::S_IDLE;
                  nxt_cur.first = cur_ff.auto_en && diff;
               end
            end
         end
         default: nxt_cur.st = adc_seq_pkg::S_IDLE;
      endcase

      // Flag set after any software clear, so a same-cycle event wins
      if (nxt_cur.done) begin
         nxt_cur.flag = 1'b1;
      end

      // Selection buffer frozen during a conversion until its last cycle
      if (nxt_cur.st != adc_seq_pkg::S_CONV
            || nxt_cur.hcnt >= 6'(nxt_cur.len - 6'h02)) begin
         nxt_cur.ref_buf = nxt_cur.ref_sw;
         nxt_cur.chan_buf = nxt_cur.chan_sw;
      end

      // Disabled: divider in reset, next conversion is a first one
      if (!nxt_cur.enable) begin
         nxt_cur.presc = 7'h00;
         nxt_cur.hrclk = 1'b0;
         nxt_cur.st = adc_seq_pkg::S_IDLE;
         nxt_cur.first = 1'b1;
         nxt_cur.sample = 1'b0;
      end
      nxt_cur.ref_out = nxt_cur.enable ? nxt_cur.ref_buf : 2'h0;
      nxt_cur.chan_out = nxt_cur.enable ? nxt_cur.chan_buf : 5'h00;

      // Ready flags registered so bus outputs come from flops
      nxt_cur.bus.awready = !nxt_cur.bus.aw_got && !nxt_cur.bus.bvalid;
      nxt_cur.bus.wready = !nxt_cur.bus.w_got && !nxt_cur.bus.bvalid;
      nxt_cur.bus.arready = !nxt_cur.bus.rvalid;
      // Busy kept as its own flop so the output needs no state decode
      nxt_cur.busy = (nxt_cur.st == adc_seq_pkg::S_CONV);
   end

   // State register
   always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         cur_ff <= '0;
         cur_ff.st <= adc_seq_pkg::S_IDLE;
         cur_ff.first <= 1'b1;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   // Outputs straight from the state flops
   assign S_AXI_AWREADY_O = cur_ff.bus.awready;
   assign S_AXI_WREADY_O = cur_ff.bus.wready;
   assign S_AXI_BVALID_O = cur_ff.bus.bvalid;
   assign S_AXI_BRESP_O = cur_ff.bus.bresp;
   assign S_AXI_ARREADY_O = cur_ff.bus.arready;
   assign S_AXI_RVALID_O = cur_ff.bus.rvalid;
   assign S_AXI_RDATA_O = {24'h000000, cur_ff.bus.rdata};
   assign S_AXI_RRESP_O = cur_ff.bus.rresp;
   assign ENABLE_O = cur_ff.enable;
   assign CHANNEL_O = cur_ff.chan_out;
   assign REFERENCE_O = cur_ff.ref_out;
   assign SAMPLE_O = cur_ff.sample;
   assign DONE_O = cur_ff.done;
   assign BUSY_O = cur_ff.busy;

   default clocking cb @(posedge CLK_SYS_I);
   endclocking
   default disable iff (!RESETN_I);

   // Checks on sequencing, all on the system clock
   a_lock_keeps_result: assert property (
      (cur_ff.st == adc_seq_pkg::S_CONV && at_end && cur_ff.lock)
      |=> $stable(cur_ff.result)) else $error("result changed while locked");
   a_flag_on_done: assert property (
      DONE_O |-> cur_ff.flag)
      else $error("flag not set on completion");
   a_single_clears: assert property (
      (DONE_O && !cur_ff.auto_en && cur_ff.enable) |-> cur_ff.st == adc_seq_pkg::S_IDLE)
      else $error("start not cleared in single mode");
   a_free_keeps_busy: assert property (
      (DONE_O && cur_ff.auto_en && cur_ff.tsel == `TSEL_FREE && cur_ff.enable) |-> BUSY_O)
      else $error("free run did not restart");
   a_presc_held: assert property (
      !cur_ff.enable |-> cur_ff.presc == 7'h00)
      else $error("prescaler runs while disabled");
   a_armed_waits_tick: assert property (
      (cur_ff.st == adc_seq_pkg::S_ARMED && !full_tick && cur_ff.enable)
      |=> cur_ff.st == adc_seq_pkg::S_ARMED) else $error("start before converter clock edge");
   a_trig_delay: assert property (
      (fire && cur_ff.st == adc_seq_pkg::S_IDLE)
      |=> BUSY_O && cur_ff.presc == 7'h00 && cur_ff.sh_at >= `SH_AUTO)
      else $error("trigger did not reset prescaler and start");
   a_sel_frozen: assert property (
      (BUSY_O && $past(BUSY_O) && cur_ff.hcnt < 6'(cur_ff.len - 6'h02)
      && $past(cur_ff.hcnt) != 6'h00) |-> $stable(cur_ff.chan_buf))
      else $error("selection moved mid conversion");
   a_disabled_sel: assert property (
      !cur_ff.enable |-> CHANNEL_O == 5'h00 && REFERENCE_O == 2'h0)
      else $error("selection applied while disabled");
   a_first_len: assert property (
      $rose(BUSY_O) && $past(cur_ff.first) |-> cur_ff.len == `HC_FIRST)
      else $error("first conversion has wrong length");
   a_busy_ignores: assert property (
      (BUSY_O && fire) |=> BUSY_O || DONE_O)
      else $error("trigger disturbed conversion");

   // Strobes last one cycle; sampling falls inside a conversion
   a_done_pulse: assert property (
      DONE_O |=> !DONE_O)
      else $error("completion strobe longer than one cycle");
   a_sample_pulse: assert property (
      SAMPLE_O |=> !SAMPLE_O)
      else $error("sample strobe longer than one cycle");
   a_sample_busy: assert property (
      SAMPLE_O |-> BUSY_O)
      else $error("sample strobe outside a conversion");

   // Result capture and the read lock
   a_result_taken: assert property (
      (cur_ff.st == adc_seq_pkg::S_CONV && at_end && !cur_ff.lock)
      |=> cur_ff.result == $past(SAR_RESULT_I)) else $error("result not captured");
   a_lo_locks: assert property (
      (rd_do && S_AXI_ARADDR_I == `ADDR_RES_LO) |=> cur_ff.lock)
      else $error("low byte read did not lock");
   a_hi_unlocks: assert property (
      (rd_do && S_AXI_ARADDR_I == `ADDR_RES_HI) |=> !cur_ff.lock)
      else $error("high byte read did not unlock");

   // A disabled converter sits idle with its divider phase cleared
   a_disabled_idle: assert property (
      !cur_ff.enable |-> !BUSY_O && !cur_ff.hrclk)
      else $error("converter active while disabled");

   // Sample point and length chosen by how the conversion began
   a_first_sample: assert property (
      $rose(BUSY_O) && $past(cur_ff.first) |-> cur_ff.sh_at == `SH_FIRST)
      else $error("first conversion samples at wrong point");
   a_normal_sample: assert property (
      ($rose(BUSY_O) && $past(cur_ff.st == adc_seq_pkg::S_ARMED) && !$past(cur_ff.first))
      |-> cur_ff.sh_at == `SH_NORMAL) else $error("software start samples at wrong point");
   a_auto_len: assert property (
      ($rose(BUSY_O) && $past(cur_ff.st == adc_seq_pkg::S_IDLE) && !$past(cur_ff.first))
      |-> cur_ff.len == `HC_NORMAL && cur_ff.sh_at == `SH_AUTO)
      else $error("triggered conversion has wrong timing");
   a_diff_auto_first: assert property (
      (cur_ff.st == adc_seq_pkg::S_CONV && at_end && cur_ff.auto_en && !free_run && diff)
      |=> cur_ff.first) else $error("differential trigger not made extended");

   c_single: cover property (DONE_O && !cur_ff.auto_en);
   c_free_run: cover property (DONE_O ##1 BUSY_O [*3]);
   c_lost_result: cover property (DONE_O && cur_ff.lock);
   c_trigger: cover property (fire && cur_ff.st == adc_seq_pkg::S_IDLE);
   c_first_conv: cover property ($rose(BUSY_O) && cur_ff.len == `HC_FIRST);
endmodule
`default_nettype wire

// ### test/sar_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module sar_core_model (
   input wire logic clk_i, // System clock
   input wire logic rst_n_i, // Async reset, active low
   input wire logic enable_i, // Converter powered
   input wire logic sample_i, // Sample-and-hold strobe
   output logic [9:0] code_o // Code for the sequencer
);
   // New code per sample, held to completion; powered down it never sits still
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         code_o <= 10'h2A5;
      end else if (!enable_i) begin
         code_o <= ~code_o;
      end else if (sample_i) begin
         code_o <= code_o + 10'h13B;
      end
   end
endmodule
`default_nettype wire

// ### test/adc_conversion_sequencer_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "adc_seq_regs.svh"
module adc_conversion_sequencer_bench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [7:0] trig = 8'h00;
   logic [31:0] wdata = 32'h00000000;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, en, sample, done, busy;
   logic [1:0] bresp, rresp, refsel;
   logic [31:0] rdata;
   logic [9:0] code;
   logic [9:0] last_code;
   logic [4:0] chan;
   logic [7:0] d;
   logic [1:0] r;
   int err_total = 0;
   int samples_checked = 0;
   int cycles = 0;
   int done_cnt = 0;
   int n;

   adc_conversion_sequencer adc_conversion_sequencer_i (
      .CLK_SYS_I(clk), .RESETN_I(rst_n),
      .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
      .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wvalid),
      .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
      .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
      .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
      .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .TRIGGER_I(trig),
      .SAR_RESULT_I(code), .ENABLE_O(en), .CHANNEL_O(chan), .REFERENCE_O(refsel),
      .SAMPLE_O(sample), .DONE_O(done), .BUSY_O(busy));

   sar_core_model sar_core_model_i (.clk_i(clk), .rst_n_i(rst_n), .enable_i(en),
      .sample_i(sample), .code_o(code));

   // Clock, 8 ns period
   initial begin
      forever #4 clk = ~clk;
   end

   // Completion tally, code at completion, hang guard
   always @(posedge clk) begin
      cycles++;
      if (done === 1'b1) begin
         done_cnt++;
         last_code <= code;
      end
      if (cycles == 6000) begin
         err_total++;
         wrap_up();
      end
   end

   task check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task wrap_up();
      if (err_total == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Both channels offered together, each released when taken
   task wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] er);
      logic aw_ok;
      logic w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge clk);
      awaddr <= a;
      wdata <= {24'h000000, v};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge clk);
         if (awvalid && awready === 1'b1) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready === 1'b1) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      while (bvalid !== 1'b1) @(posedge clk);
      bready <= 1'b0;
      check(bresp, er);
   endtask

   task rd(input logic [7:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge clk);
      d = rdata[7:0];
      r = rresp;
      rready <= 1'b0;
   endtask

   // Cycles until done (0), sample (1) is seen at an edge
   task wait_on(input int which, output int k);
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (((which == 0) ? done : sample) !== 1'b1);
   endtask

   task t_map();
      rd(8'h14);
      check(r, `RESP_SLVERR);
      check(d, 8'h00);
      wr(8'h14, 8'hFF, `RESP_SLVERR);
      rd(`ADDR_CTRL);
      check(d, 8'h00);
   endtask

   task t_gate();
      wr(`ADDR_CHAN, 8'h45, `RESP_OKAY);
      wr(`ADDR_SPECIAL, 8'h40, `RESP_OKAY);
      repeat (3) @(posedge clk);
      check({refsel, chan}, 7'h00);
      wr(`ADDR_CTRL, 8'h82, `RESP_OKAY);
      repeat (3) @(posedge clk);
      check({en, refsel, chan}, 8'hA5);
   endtask

   // First conversion, alignment, channel hold, read lock
   task t_single();
      logic [9:0] e;
      wr(`ADDR_CTRL, 8'hC2, `RESP_OKAY);
      rd(`ADDR_CTRL);
      check(d[6], 1'b1);
      wr(`ADDR_CHAN, 8'h46, `RESP_OKAY);
      check(chan, 5'h05);
      wait_on(0, n);
      check(n >= 80 && n <= 100, 1'b1);
      repeat (3) @(posedge clk);
      check(chan, 5'h06);
      e = last_code;
      rd(`ADDR_CTRL);
      check(d & 8'h50, 8'h10);
      rd(`ADDR_RES_LO);
      check(d, e[7:0]);
      rd(`ADDR_RES_HI);
      check(d, {6'h00, e[9:8]});
      wr(`ADDR_CHAN, 8'h66, `RESP_OKAY);
      rd(`ADDR_RES_LO);
      check(d, {e[1:0], 6'h00});
      rd(`ADDR_RES_HI);
      check(d, e[9:2]);
      wr(`ADDR_CHAN, 8'h46, `RESP_OKAY);
      rd(`ADDR_RES_LO);
      wr(`ADDR_CTRL, 8'hD2, `RESP_OKAY);
      wait_on(0, n);
      check(n >= 40 && n <= 60, 1'b1);
      rd(`ADDR_CTRL);
      check(d[4], 1'b1);
      rd(`ADDR_RES_HI);
      check(d, {6'h00, e[9:8]});
      rd(`ADDR_RES_LO);
      check(d, e[7:0]);
      rd(`ADDR_RES_HI);
   endtask

   // Trigger edge, edge during conversion, level held at completion
   task t_auto();
      int c0;
      wr(`ADDR_CTRL, 8'hB2, `RESP_OKAY);
      c0 = done_cnt;
      @(posedge clk);
      trig <= 8'h04;
      wait_on(1, n);
      check(n >= 10 && n <= 13, 1'b1);
      @(posedge clk);
      trig <= 8'h00;
      @(posedge clk);
      trig <= 8'h04;
      repeat (300) @(posedge clk);
      check(done_cnt - c0, 1);
      trig <= 8'h00;
      @(posedge clk);
      trig <= 8'h04;
      wait_on(0, n);
      check(n >= 53 && n <= 60, 1'b1);
      trig <= 8'h00;
   endtask

   // Free run, single ended then differential, then disable
   task t_free();
      logic [7:0] chans [2] = '{8'h41, 8'h49};
      int period [2] = '{52, 56};
      for (int i = 0; i < 2; i++) begin
         wr(`ADDR_CHAN, chans[i], `RESP_OKAY);
         wr(`ADDR_SPECIAL, 8'h00, `RESP_OKAY);
         wr(`ADDR_CTRL, 8'hF2, `RESP_OKAY);
         wait_on(0, n);
         wait_on(0, n);
         check(n, period[i]);
         wait_on(1, n);
         if (i == 0) begin
            check(n >= 5 && n <= 8, 1'b1);
         end
         rd(`ADDR_CTRL);
         check(d[6], 1'b1);
         wr(`ADDR_CTRL, 8'h02, `RESP_OKAY);
         repeat (3) @(posedge clk);
         check({busy, en, chan}, 7'h00);
      end
   endtask

   // Main sequence
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      t_map();
      t_gate();
      t_single();
      t_auto();
      t_free();
      wrap_up();
   end
endmodule
`default_nettype wire
